// ### rtl/pin_mux_defs.svh
// Register indexes, field positions and reset values for the pin block
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH

// ---------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_SHARED_DIR 16'hff30
`define IDX_SHARED_DATA 16'hff31
`define IDX_SHARED_ODR 16'hff32
`define IDX_SHARED_LEVELS 16'hff33
`define IDX_INPUT_PIN_LEVELS 16'hff53

// ---------------------------------------------------------------
// Widths and field positions
// ---------------------------------------------------------------
`define ADDR_W 18
`define SHARED_PINS 2
`define INPUT_PINS 8
`define SYNC_W 10
`define FLD_BIT0 0
`define FLD_BIT1 1
`define STRB_LOW_LANE 0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_SHARED_DIR 2'h0
`define RST_SHARED_DATA 2'h0
`define RST_SHARED_ODR 2'h0
`define RST_PIN_OUT 2'h0
`define RST_PIN_OE_N 2'h3
`define RST_SYNC 10'h000

`endif

// ### rtl/pin_mux_pkg.sv
// Types shared by the pin block
`default_nettype none

package pin_mux_pkg;

	typedef enum logic [1:0]
	{
		bus_idle = 2'b00,
		bus_answer = 2'b01
	} bus_state_type;

	typedef enum logic [2:0]
	{
		sel_none = 3'h0,
		sel_dir = 3'h1,
		sel_data = 3'h2,
		sel_odr = 3'h3,
		sel_shared_levels = 3'h4,
		sel_input_levels = 3'h5
	} reg_sel_type;

endpackage : pin_mux_pkg

`default_nettype wire

// ### rtl/pin_sync.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// The first stage feeds only the second one
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge ref_clk or negedge resetn)
			begin
				if (!resetn)
				begin
					meta_r[i] <= 1'b0;
					sync_r[i] <= 1'b0;
				end
				else
				begin
					meta_r[i] <= async_in[i];
					sync_r[i] <= meta_r[i];
				end
			end
		end
	endgenerate

	assign sync_out = sync_r;

endmodule : pin_sync

`default_nettype wire

// ### rtl/serial_pin_mux_and_input_port.sv
// Shared serial/port pin mux for two pins and an eight-pin input port, APB slave
//
// Summary of operation
// [R1] Pin 1 drives serial 1 transmit data when enabled, else direction bit decides.
// [R2] Pin 0 drives serial 0 transmit data when enabled, else direction bit decides.
// [R3] Port output with open-drain bit set only pulls low, never drives high.
// [R4] Input port is eight pins, input only, never driven by port logic.
// [R5] Input port behaves the same in every operating mode.
// [R6] Reading the input pin register returns live pin levels, no stored value.
// [R7] Writes to the input pin register change nothing; register is read-only.
// [R8] Register bits 7..0 follow input pins 7..0 in the same order.
// [R9] Input pins stay digitally readable while shared with analog functions.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pin_mux_defs.svh"

module serial_pin_mux_and_input_port (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial0_transmit_enable,
	input wire logic serial1_transmit_enable,
	input wire logic serial0_transmit_out,
	input wire logic serial1_transmit_out,
	input wire logic [`SHARED_PINS-1:0] shared_pin_in,
	output logic [`SHARED_PINS-1:0] shared_pin_out,
	output logic [`SHARED_PINS-1:0] shared_pin_oe_n,
	input wire logic [`INPUT_PINS-1:0] input_pin // R4 R5
);

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	function automatic pin_mux_pkg::reg_sel_type decode(input logic [`ADDR_W-1:0] addr);
		pin_mux_pkg::reg_sel_type sel;
		sel = pin_mux_pkg::sel_none;
		if (addr[1:0] == 2'h0)
		begin
			case (addr[`ADDR_W-1:2])
				`IDX_SHARED_DIR: sel = pin_mux_pkg::sel_dir;
				`IDX_SHARED_DATA: sel = pin_mux_pkg::sel_data;
				`IDX_SHARED_ODR: sel = pin_mux_pkg::sel_odr;
				`IDX_SHARED_LEVELS: sel = pin_mux_pkg::sel_shared_levels;
				`IDX_INPUT_PIN_LEVELS: sel = pin_mux_pkg::sel_input_levels;
				default: sel = pin_mux_pkg::sel_none;
			endcase
		end
		return sel;
	endfunction : decode

	// Pin drive: returns {oe_n, out}
	function automatic logic [1:0] pin_drive(
		input logic xmit_en,
		input logic tx,
		input logic dir,
		input logic data,
		input logic odr
	);
		logic [1:0] drv;
		drv = 2'h2;
		if (xmit_en)
			drv = {1'b0, tx};
		else if (dir && odr)
			drv = {data, 1'b0};
		else if (dir)
			drv = {1'b0, data};
		else
			drv = 2'h2;
		return drv;
	endfunction : pin_drive

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [`SYNC_W-1:0] levels_sync;
	logic [`INPUT_PINS-1:0] input_levels;
	logic [`SHARED_PINS-1:0] shared_levels;

	// Input pins are sampled with no analog or mode gating, so they stay readable
	pin_sync #(
		.WIDTH(`SYNC_W)
	) u_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.async_in({shared_pin_in, input_pin}),
		.sync_out(levels_sync)
	); // R9

	assign input_levels = levels_sync[`INPUT_PINS-1:0]; // R8
	assign shared_levels = levels_sync[`SYNC_W-1:`INPUT_PINS];

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	pin_mux_pkg::bus_state_type state_r;
	pin_mux_pkg::bus_state_type state_nxt;
	pin_mux_pkg::reg_sel_type sel;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic wr_commit;
	logic [`SHARED_PINS-1:0] dir_r;
	logic [`SHARED_PINS-1:0] dir_nxt;
	logic [`SHARED_PINS-1:0] data_r;
	logic [`SHARED_PINS-1:0] data_nxt;
	logic [`SHARED_PINS-1:0] odr_r;
	logic [`SHARED_PINS-1:0] odr_nxt;

	assign sel = decode(paddr);
	assign wr_commit = psel && penable && pready_r && pwrite && pstrb[`STRB_LOW_LANE];

	// One wait state keeps read data registered at the cost of a cycle
	always_comb
	begin
		state_nxt = state_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		prdata_nxt = 32'h0000_0000;
		case (state_r)
			pin_mux_pkg::bus_idle:
			begin
				if (psel && penable)
				begin
					state_nxt = pin_mux_pkg::bus_answer;
					pready_nxt = 1'b1;
					pslverr_nxt = (sel == pin_mux_pkg::sel_none);
					if (!pwrite)
					begin
						case (sel)
							pin_mux_pkg::sel_dir: prdata_nxt[`SHARED_PINS-1:0] = dir_r;
							pin_mux_pkg::sel_data: prdata_nxt[`SHARED_PINS-1:0] = data_r;
							pin_mux_pkg::sel_odr: prdata_nxt[`SHARED_PINS-1:0] = odr_r;
							pin_mux_pkg::sel_shared_levels:
								prdata_nxt[`SHARED_PINS-1:0] = shared_levels;
							pin_mux_pkg::sel_input_levels:
								prdata_nxt[`INPUT_PINS-1:0] = input_levels; // R6
							default: prdata_nxt = 32'h0000_0000;
						endcase
					end
				end
			end
			pin_mux_pkg::bus_answer: state_nxt = pin_mux_pkg::bus_idle;
			default: state_nxt = pin_mux_pkg::bus_idle;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= pin_mux_pkg::bus_idle;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			state_r <= state_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	// The input pin register has no storage, so a write there falls through
	always_comb
	begin
		dir_nxt = dir_r;
		data_nxt = data_r;
		odr_nxt = odr_r;
		if (wr_commit)
		begin
			case (sel)
				pin_mux_pkg::sel_dir: dir_nxt = pwdata[`SHARED_PINS-1:0];
				pin_mux_pkg::sel_data: data_nxt = pwdata[`SHARED_PINS-1:0];
				pin_mux_pkg::sel_odr: odr_nxt = pwdata[`SHARED_PINS-1:0];
				default: dir_nxt = dir_r; // R7
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dir_r <= `RST_SHARED_DIR;
			data_r <= `RST_SHARED_DATA;
			odr_r <= `RST_SHARED_ODR;
		end
		else
		begin
			dir_r <= dir_nxt;
			data_r <= data_nxt;
			odr_r <= odr_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Shared pin mux
	// ---------------------------------------------------------------
	logic [`SHARED_PINS-1:0] xmit_en;
	logic [`SHARED_PINS-1:0] tx;
	logic [1:0] drive [`SHARED_PINS];
	logic [`SHARED_PINS-1:0] pin_out_r;
	logic [`SHARED_PINS-1:0] pin_out_nxt;
	logic [`SHARED_PINS-1:0] pin_oe_n_r;
	logic [`SHARED_PINS-1:0] pin_oe_n_nxt;

	assign xmit_en = {serial1_transmit_enable, serial0_transmit_enable};
	assign tx = {serial1_transmit_out, serial0_transmit_out};

	// Transmit enable overrides the direction bit; open drain only on port output
	genvar i;
	generate
		for (i = 0; i < `SHARED_PINS; i++)
		begin : g_pin
			assign drive[i] = pin_drive(xmit_en[i], tx[i], dir_r[i], data_r[i], odr_r[i]); // R1 R2 R3
			assign pin_out_nxt[i] = drive[i][0];
			assign pin_oe_n_nxt[i] = drive[i][1];
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_out_r <= `RST_PIN_OUT;
			pin_oe_n_r <= `RST_PIN_OE_N;
		end
		else
		begin
			pin_out_r <= pin_out_nxt;
			pin_oe_n_r <= pin_oe_n_nxt;
		end
	end

	assign shared_pin_out = pin_out_r;
	assign shared_pin_oe_n = pin_oe_n_r;

	// The input port has no output path and no mode input at all

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	chk_bit1_tx_route: assert property ( // R1
		@(posedge ref_clk) disable iff (!resetn)
		serial1_transmit_enable |=>
			!shared_pin_oe_n[`FLD_BIT1] && shared_pin_out[`FLD_BIT1] == $past(serial1_transmit_out))
		else $error("bit1 not driving serial transmit data");

	chk_bit1_port_in: assert property ( // R1
		@(posedge ref_clk) disable iff (!resetn)
		(!serial1_transmit_enable && !dir_r[`FLD_BIT1]) |=> shared_pin_oe_n[`FLD_BIT1])
		else $error("bit1 driven while port input");

	chk_bit0_tx_route: assert property ( // R2
		@(posedge ref_clk) disable iff (!resetn)
		serial0_transmit_enable |=>
			!shared_pin_oe_n[`FLD_BIT0] && shared_pin_out[`FLD_BIT0] == $past(serial0_transmit_out))
		else $error("bit0 not driving serial transmit data");

	chk_bit0_port_out: assert property ( // R2
		@(posedge ref_clk) disable iff (!resetn)
		(!serial0_transmit_enable && dir_r[`FLD_BIT0] && !odr_r[`FLD_BIT0]) |=>
			!shared_pin_oe_n[`FLD_BIT0] && shared_pin_out[`FLD_BIT0] == $past(data_r[`FLD_BIT0]))
		else $error("bit0 port output wrong");

	chk_open_drain_high: assert property ( // R3
		@(posedge ref_clk) disable iff (!resetn)
		!shared_pin_oe_n[`FLD_BIT0] |-> !shared_pin_out[`FLD_BIT0] ||
			!$past(odr_r[`FLD_BIT0]) || $past(serial0_transmit_enable) || !$past(dir_r[`FLD_BIT0]))
		else $error("open drain pin driven high");

	chk_live_levels: assert property ( // R6
		@(posedge ref_clk) disable iff (!resetn)
		(state_r == pin_mux_pkg::bus_idle && psel && penable && !pwrite &&
			sel == pin_mux_pkg::sel_input_levels) |=>
			pready && !pslverr && prdata[`INPUT_PINS-1:0] == $past(input_levels))
		else $error("input pin read not live");

	chk_readonly_write: assert property ( // R7
		@(posedge ref_clk) disable iff (!resetn)
		(wr_commit && sel == pin_mux_pkg::sel_input_levels) |=>
			$stable(dir_r) && $stable(data_r) && $stable(odr_r))
		else $error("write to input pin register changed state");

	chk_bit_order: assert property ( // R8
		@(posedge ref_clk) disable iff (!resetn)
		(pready && $past(sel) == pin_mux_pkg::sel_input_levels && !$past(pwrite)) |->
			prdata[31:`INPUT_PINS] == 24'h00_0000 &&
			prdata[7] == $past(levels_sync[7]) && prdata[0] == $past(levels_sync[0]))
		else $error("input pin bit order wrong");

	chk_apb_answer: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		(psel && penable && !pready) |=> pready)
		else $error("APB answer late");

endmodule : serial_pin_mux_and_input_port

`default_nettype wire

// ### bench/pin_board_model.sv
// Board model: pull-ups on the shared pins, driven levels on the input port
`timescale 1ns/10ps
`default_nettype none

module pin_board_model (
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe_n,
	input wire logic [7:0] board_level,
	output logic [1:0] shared_level,
	output logic [7:0] port_level
);
	// A released pin floats up to the board pull-up, never to the last driven value
	assign shared_level = pin_oe_n | pin_out;
	// Analog use on the board leaves the digital level readable
	assign port_level = board_level;
endmodule : pin_board_model
`default_nettype wire

// ### bench/tb_serial_pin_mux_and_input_port.sv
// Testbench for the shared pin mux and the input-only port
`timescale 1ns/10ps
`default_nettype none
`include "pin_mux_defs.svh"

module tb_serial_pin_mux_and_input_port;
	localparam logic [`ADDR_W-1:0] a_dir = `ADDR_W'(`IDX_SHARED_DIR * 4);
	localparam logic [`ADDR_W-1:0] a_dat = `ADDR_W'(`IDX_SHARED_DATA * 4);
	localparam logic [`ADDR_W-1:0] a_odr = `ADDR_W'(`IDX_SHARED_ODR * 4);
	localparam logic [`ADDR_W-1:0] a_lvl = `ADDR_W'(`IDX_SHARED_LEVELS * 4);
	localparam logic [`ADDR_W-1:0] a_in = `ADDR_W'(`IDX_INPUT_PIN_LEVELS * 4);
	logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, er, eo, ed;
	logic [`ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [1:0] tx_en, tx_dat, pin_out, pin_oe_n, lvl;
	logic [7:0] board_level, port_level;
	logic [7:0] pat [4] = '{8'ha5, 8'h5a, 8'h80, 8'h01};
	int bad_count, samples_checked;

	serial_pin_mux_and_input_port serial_pin_mux_and_input_port_inst (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.serial0_transmit_enable(tx_en[0]),
		.serial1_transmit_enable(tx_en[1]),
		.serial0_transmit_out(tx_dat[0]),
		.serial1_transmit_out(tx_dat[1]),
		.shared_pin_in(lvl),
		.shared_pin_out(pin_out),
		.shared_pin_oe_n(pin_oe_n),
		.input_pin(port_level)
	);

	pin_board_model pin_board_model_inst (
		.pin_out(pin_out),
		.pin_oe_n(pin_oe_n),
		.board_level(board_level),
		.shared_level(lvl),
		.port_level(port_level)
	);

	// ----------------------------------------
	// Bus cycles and comparison
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : check

	// Waits on pready with a bound so a dead slave cannot hang the run
	task automatic apb(input logic wr, input logic [`ADDR_W-1:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 20)
			bad_count++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task close_out;
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	initial
	begin
		#100000;
		bad_count++;
		close_out();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hf;
		tx_en = 2'h0;
		tx_dat = 2'h0;
		board_level = 8'h00;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		check({30'h0, pin_oe_n}, 32'h00000003);
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b0, a_dir + `ADDR_W'(4 * k), 32'h0);
			check(rd, 32'h0);
		end
		for (int k = 0; k < 4; k++)
		begin
			board_level <= pat[k];
			repeat (3) @(posedge ref_clk);
			apb(1'b0, a_in, 32'h0);
			check(rd, {24'h0, pat[k]});
		end
		apb(1'b1, a_in, 32'hffffffff);
		check({31'h0, er}, 32'h0);
		apb(1'b0, a_in, 32'h0);
		check(rd, 32'h00000001);
		apb(1'b0, a_dir, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, `ADDR_W'(0), 32'h0);
		check({31'h0, er}, 32'h1);
		check(rd, 32'h0);
		apb(1'b0, a_dir + `ADDR_W'(1), 32'h0);
		check({31'h0, er}, 32'h1);
		pstrb <= 4'he;
		apb(1'b1, a_dir, 32'h3);
		pstrb <= 4'hf;
		apb(1'b0, a_dir, 32'h0);
		check(rd, 32'h0);
		// Every mix of enable, transmit data, direction, data and open drain per pin
		for (int p = 0; p < 2; p++)
		begin
			for (int k = 0; k < 32; k++)
			begin
				tx_en <= 2'(k[4]) << p;
				tx_dat <= 2'(k[3]) << p;
				apb(1'b1, a_dir, 32'(k[2]) << p);
				apb(1'b1, a_dat, 32'(k[1]) << p);
				apb(1'b1, a_odr, 32'(k[0]) << p);
				repeat (3) @(posedge ref_clk);
				eo = (k[4] == 1'b0) && (k[2] == 1'b0 || (k[0] == 1'b1 && k[1] == 1'b1));
				ed = k[4] ? k[3] : k[1];
				check({31'h0, pin_oe_n[p]}, {31'h0, eo});
				if (eo == 1'b0)
					check({31'h0, pin_out[p]}, {31'h0, ed});
				apb(1'b0, a_lvl, 32'h0);
				check(rd, 32'(2'b11 ^ (2'(!(eo | ed)) << p)));
				apb(1'b0, a_in, 32'h0);
				check(rd, 32'h00000001);
			end
		end
		// Reset in mid-run must release the pins even with transmit enabled
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check({30'h0, pin_oe_n}, 32'h00000003);
		resetn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		check({30'h0, pin_oe_n}, 32'h00000001);
		check({31'h0, pin_out[1]}, 32'h1);
		apb(1'b0, a_in, 32'h0);
		check(rd, 32'h00000001);
		close_out();
	end
endmodule : tb_serial_pin_mux_and_input_port
`default_nettype wire
